// *** src/boot_image_block_parser.sv ***
// Notes on behaviour
// [RULE1] Coefficient word is four bytes, LS byte first; only bits 27..0 meaningful.
// [RULE2] Coefficient payload length is four times the word count.
// [RULE3] Data word is six bytes, LS byte first, forming bits 47..0.
// [RULE4] Data payload length is six times the word count.
// [RULE5] Payload starts at block offset 12, after the twelve-byte header.
// [RULE6] Trailer at offset N+12: two zero bytes, checksum MS then LS byte.
// [RULE7] Header offsets 8,9 hold total count MS first; zero means termination.
// [RULE8] Image ends with 20-byte block: 0000, 001F, then sixteen zero bytes.
// [RULE9] Coefficient words keep only 28 valid bits; bits 31..28 dropped.
`timescale 1ns/1ns
`include "boot_parser_regs.svh"
module boot_image_block_parser
  import boot_parser_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        restart,
  input  wire logic        link_clk,
  input  wire logic [7:0]  link_byte,
  input  wire logic [1:0]  dest_kind,
  output logic             word_valid,
  output logic [47:0]      word_data,
  output logic             word_is_coef,
  output logic             cksum_valid,
  output logic [15:0]      cksum,
  output logic             fmt_err,
  output logic             image_done
);

  word_if wif ();

  logic [2:0]  clk_sync;
  logic [7:0]  byte_s1;
  logic [7:0]  byte_s2;
  logic        rx_stb;
  logic [7:0]  rx_byte;
  state_t      state;
  state_t      next_state;
  logic [15:0] off;
  logic [15:0] total;
  logic [15:0] n_len;
  dest_t       dest;
  logic        term_bad;
  logic        trl_bad;

  // Link strobe and byte pass two flops; equal delay keeps them aligned
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      clk_sync <= 3'b000;
      byte_s1  <= 8'h00;
      byte_s2  <= 8'h00;
    end else begin
      clk_sync <= {clk_sync[1:0], link_clk};
      byte_s1  <= link_byte;
      byte_s2  <= byte_s1;
    end
  end

  wire link_rise = clk_sync[1] & ~clk_sync[2];

  // One-cycle byte event, registered so all decoding below sees a stable byte
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_stb  <= 1'b0;
      rx_byte <= 8'h00;
    end else begin
      rx_stb  <= link_rise;
      if (link_rise) rx_byte <= byte_s2;
    end
  end

  // Offset decoding
  wire        last_hdr   = off == (`HDR_LEN - 16'd1);
  wire [15:0] hdr_total  = total;
  wire        total_zero = hdr_total == 16'h0000;                                  // [RULE7]
  wire [15:0] hdr_n      = hdr_total - (`HDR_LEN + `TRAILER_LEN);                  // [RULE7]
  wire        short_blk  = hdr_total < (`HDR_LEN + `TRAILER_LEN);
  wire        kind_mem   = dest_kind == DEST_COEF || dest_kind == DEST_DATA;
  wire [15:0] pay_end    = n_len + (`HDR_LEN - 16'd1);                              // [RULE5]
  wire [15:0] trl_idx    = off - (n_len + `HDR_LEN);                                // [RULE6]
  wire        blk_end    = off == (total - 16'd1);
  wire [7:0]  term_exp   = (off == `TERM_MARK_OFF) ? `TERM_MARK_BYTE : 8'h00;       // [RULE8]
  wire        term_miss  = rx_byte != term_exp;
  wire        term_last  = off == `TERM_LAST_OFF;
  wire        trl_zero_b = trl_idx < `TRL_MSB_IDX;
  wire        trl_last   = trl_idx == `TRL_LSB_IDX;
  wire        leaving    = (state == ST_TRL && trl_last) || (state == ST_SKIP && blk_end);

  // Block sequencing, advanced only on a received byte
  always_comb begin
    next_state = state;
    unique case (state)
      ST_HDR: begin
        if (last_hdr) begin
          if (total_zero) next_state = ST_TERM;                                   // [RULE7]
          else if (!kind_mem) next_state = ST_SKIP;
          else if (short_blk) next_state = ST_DONE;
          else if (hdr_n == 16'h0000) next_state = ST_TRL;
          else next_state = ST_PAY;                                                // [RULE5]
        end
      end
      ST_PAY:  if (off == pay_end) next_state = ST_TRL;                            // [RULE6]
      ST_TRL:  if (trl_last) next_state = ST_HDR;
      ST_SKIP: if (blk_end) next_state = ST_HDR;
      ST_TERM: if (term_last) next_state = ST_DONE;                                // [RULE8]
      ST_DONE: next_state = ST_DONE;
      default: next_state = ST_DONE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= ST_HDR;
      off   <= 16'h0000;
    end else if (restart) begin
      state <= ST_HDR;
      off   <= 16'h0000;
    end else if (rx_stb) begin
      state <= next_state;
      off   <= leaving ? 16'h0000 : off + 16'd1;
    end
  end

  // Header capture: count MS byte first, destination and N at the last header byte
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      total <= 16'h0000;
      n_len <= 16'h0000;
      dest  <= DEST_OTHER;
    end else if (rx_stb && state == ST_HDR) begin
      if (off == `CNT_MSB_OFF) total[15:8] <= rx_byte;                            // [RULE7]
      if (off == `CNT_LSB_OFF) total[7:0]  <= rx_byte;                            // [RULE7]
      if (last_hdr) begin
        n_len <= hdr_n;
        dest  <= dest_t'(dest_kind);
      end
    end
  end

  // Termination pattern runs from offset 0, so header bytes are checked too
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      term_bad <= 1'b0;
    end else if (rx_stb && (state == ST_HDR || state == ST_TERM)) begin
      term_bad <= (off == 16'h0000) ? term_miss : (term_bad | term_miss);         // [RULE8]
    end
  end

  // Trailer zero bytes, and the payload must end on a word boundary
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      trl_bad <= 1'b0;
    end else if (rx_stb && state == ST_TRL) begin
      if (trl_idx == 16'h0000) trl_bad <= (rx_byte != 8'h00) | ~wif.aligned;      // [RULE2] [RULE4] [RULE6]
      else if (trl_zero_b) trl_bad <= trl_bad | (rx_byte != 8'h00);               // [RULE6]
    end
  end

  // Packer feed: only payload bytes of memory blocks
  assign wif.byte_stb  = rx_stb && state == ST_PAY;                                // [RULE5]
  assign wif.byte_data = rx_byte;
  assign wif.wide      = dest == DEST_DATA;                                         // [RULE3]
  assign wif.clear     = restart || state == ST_HDR;

  word_packer u_packer (
    .clk   (clk),
    .rst_b (rst_b),
    .wif   (wif)
  );

  wire [47:0] coef_word = {{(48 - `COEF_VALID_BITS){1'b0}}, wif.word[`COEF_VALID_BITS-1:0]}; // [RULE9]

  // Registered results; pulses last one cycle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      word_valid   <= 1'b0;
      word_data    <= 48'h0;
      word_is_coef <= 1'b0;
      cksum_valid  <= 1'b0;
      cksum        <= 16'h0000;
      fmt_err      <= 1'b0;
      image_done   <= 1'b0;
    end else begin
      word_valid  <= wif.word_stb;
      cksum_valid <= 1'b0;
      fmt_err     <= 1'b0;
      image_done  <= 1'b0;
      if (wif.word_stb) begin
        word_data    <= (dest == DEST_COEF) ? coef_word : wif.word;                // [RULE9] [RULE1]
        word_is_coef <= dest == DEST_COEF;
      end
      if (rx_stb && state == ST_TRL) begin
        if (trl_idx == `TRL_MSB_IDX) cksum[15:8] <= rx_byte;                      // [RULE6]
        if (trl_last) begin
          cksum[7:0]  <= rx_byte;                                                  // [RULE6]
          cksum_valid <= 1'b1;
          fmt_err     <= trl_bad;
        end
      end
      if (rx_stb && state == ST_HDR && last_hdr && kind_mem && !total_zero && short_blk) fmt_err <= 1'b1;
      if (rx_stb && state == ST_TERM && term_last) begin
        image_done <= ~(term_bad | term_miss);                                     // [RULE8]
        fmt_err    <= term_bad | term_miss;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_coef_mask:   assert property (word_valid && word_is_coef |-> word_data[47:28] == 20'h0) // [RULE9]
    else $error("coefficient word carries bits above 27");
  a_data_full:   assert property (word_valid && !word_is_coef |-> word_data == $past(wif.word)) // [RULE3]
    else $error("data word altered");
  a_pay_start:   assert property (rx_stb && !restart && state == ST_HDR && last_hdr && kind_mem && !short_blk
                                  && hdr_n != 16'h0 |=> state == ST_PAY && off == `HDR_LEN) // [RULE5]
    else $error("payload does not start at offset 12");
  a_n_from_cnt:  assert property (rx_stb && !restart && state == ST_HDR && last_hdr
                                  |=> n_len == $past(total) - (`HDR_LEN + `TRAILER_LEN)) // [RULE7]
    else $error("payload length not derived from total count");
  a_term_enter:  assert property (rx_stb && !restart && state == ST_HDR && last_hdr && total_zero
                                  |=> state == ST_TERM) // [RULE7]
    else $error("zero count did not enter termination");
  a_trl_after:   assert property (rx_stb && !restart && state == ST_PAY && off == pay_end |=> state == ST_TRL) // [RULE6]
    else $error("trailer not entered after byte N");
  a_cksum_bytes: assert property (cksum_valid |-> cksum[7:0] == $past(rx_byte) && $past(trl_idx) == `TRL_LSB_IDX) // [RULE6]
    else $error("checksum LS byte misplaced");
  a_term_done:   assert property (image_done |-> $past(state) == ST_TERM && $past(off) == `TERM_LAST_OFF
                                  ##1 state == ST_DONE) // [RULE8]
    else $error("termination done at wrong offset");
  a_pkt_feed:    assert property (wif.byte_stb |-> state == ST_PAY && off >= `HDR_LEN && off <= pay_end) // [RULE2] [RULE4]
    else $error("non-payload byte fed to packer");

  c_coef_word: cover property (word_valid && word_is_coef);
  c_data_word: cover property (word_valid && !word_is_coef);
  c_cksum:     cover property (cksum_valid && !fmt_err);
  c_done:      cover property (image_done);

endmodule

// *** src/boot_parser_pkg.sv ***
package boot_parser_pkg;

  typedef enum logic [1:0] {
    DEST_OTHER = 2'b00,
    DEST_COEF  = 2'b01,
    DEST_DATA  = 2'b10
  } dest_t;

  typedef enum logic [2:0] {
    ST_HDR  = 3'b000,
    ST_PAY  = 3'b001,
    ST_TRL  = 3'b010,
    ST_SKIP = 3'b011,
    ST_TERM = 3'b100,
    ST_DONE = 3'b101
  } state_t;

endpackage

// *** src/boot_parser_regs.svh ***
`ifndef BOOT_PARSER_REGS_SVH
`define BOOT_PARSER_REGS_SVH

// Block layout; header offsets count from the first header byte, trailer indices from the first trailer byte
`define HDR_LEN         16'd12
`define CNT_MSB_OFF     16'd8
`define CNT_LSB_OFF     16'd9
`define TRAILER_LEN     16'd4
`define TRL_MSB_IDX     16'd2
`define TRL_LSB_IDX     16'd3

// Word packing
`define COEF_LAST_IDX   3'd3
`define DATA_LAST_IDX   3'd5
`define COEF_VALID_BITS 28

// Termination block
`define TERM_LAST_OFF   16'd19
`define TERM_MARK_OFF   16'd3
`define TERM_MARK_BYTE  8'h1f

`endif

// *** src/word_if.sv ***
`timescale 1ns/1ns
interface word_if;
  logic        byte_stb;
  logic [7:0]  byte_data;
  logic        wide;
  logic        clear;
  logic        word_stb;
  logic [47:0] word;
  logic        aligned;

  modport packer (input byte_stb, byte_data, wide, clear, output word_stb, word, aligned);
  modport feeder (output byte_stb, byte_data, wide, clear, input word_stb, word, aligned);
endinterface

// *** src/word_packer.sv ***
`timescale 1ns/1ns
`include "boot_parser_regs.svh"
module word_packer
  import boot_parser_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  word_if.packer   wif
);

  logic [2:0]  cnt;
  logic [47:0] acc;
  logic [7:0]  first_byte;

  // Byte k of a word lands at bits 8k+7..8k, so the stream is LS byte first
  wire [47:0] placed   = {40'h0, wif.byte_data} << {cnt, 3'b000}; // [RULE1] [RULE3]
  wire [47:0] merged   = acc | placed;
  wire [2:0]  last_idx = wif.wide ? `DATA_LAST_IDX : `COEF_LAST_IDX; // [RULE2] [RULE4]
  wire        at_last  = cnt == last_idx;

  assign wif.aligned = cnt == 3'd0;

  // Accumulate; the word is handed over in the cycle after its last byte
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt          <= 3'd0;
      acc          <= 48'h0;
      wif.word     <= 48'h0;
      wif.word_stb <= 1'b0;
      first_byte   <= 8'h00;
    end else begin
      wif.word_stb <= 1'b0;
      if (wif.clear) begin
        cnt <= 3'd0;
        acc <= 48'h0;
      end else if (wif.byte_stb) begin
        if (cnt == 3'd0) first_byte <= wif.byte_data;
        if (at_last) begin
          wif.word     <= merged; // [RULE2] [RULE4]
          wif.word_stb <= 1'b1;
          cnt          <= 3'd0;
          acc          <= 48'h0;
        end else begin
          acc <= merged;
          cnt <= cnt + 3'd1;
        end
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_word_on_last:  assert property (wif.byte_stb && !wif.clear && at_last |=> wif.word_stb) // [RULE2]
    else $error("word not emitted after last byte");
  a_lsb_first:     assert property (wif.word_stb |-> wif.word[7:0] == first_byte) // [RULE1]
    else $error("first byte not in low bits");
  a_data_msb_last: assert property (wif.word_stb && wif.wide |-> wif.word[47:40] == $past(wif.byte_data)) // [RULE3]
    else $error("sixth byte not in bits 47:40");
  a_coef_msb_last: assert property (wif.word_stb && !wif.wide |->
                                    wif.word[31:24] == $past(wif.byte_data) && wif.word[47:32] == 16'h0) // [RULE1]
    else $error("fourth byte not in bits 31:24");

endmodule

// *** test/boot_mem_model.sv ***
`timescale 1ns/1ns
// Behavioural serial memory that streams the boot image one byte per link clock
module boot_mem_model (
  output logic       link_clk,
  output logic [7:0] link_byte
);
  // The link clock stands still low between frames
  initial begin
    link_clk  = 1'b0;
    link_byte = 8'h00;
  end

  // Bytes go out in image order; each is held 400 ns on both sides of the rise
  task automatic send_image(input logic [7:0] img[$]);
    #37; // Keeps the link unrelated in phase to the system clock
    foreach (img[i]) begin
      link_byte = img[i];
      #400;
      link_clk = 1'b1;
      #400;
      link_clk = 1'b0;
    end
    // Released line: show the inverse so a stale byte is never mistaken for data
    link_byte = ~link_byte;
  endtask
endmodule

// *** test/tb_boot_image_block_parser.sv ***
`timescale 1ns/1ns
module tb_boot_image_block_parser;
  import boot_parser_pkg::*;

  logic        clk;
  logic        rst_b;
  logic        restart;
  logic        link_clk;
  logic [7:0]  link_byte;
  logic [1:0]  dest_kind;
  logic        word_valid;
  logic [47:0] word_data;
  logic        word_is_coef;
  logic        cksum_valid;
  logic [15:0] cksum;
  logic        fmt_err;
  logic        image_done;
  logic [47:0] words[$];
  logic        kinds[$];
  logic [15:0] last_ck;
  int          n_fmt;
  int          n_done;
  int          n_ck;
  int          err_count;
  int          check_count;

  boot_image_block_parser boot_image_block_parser_i (
    .clk          (clk),
    .rst_b        (rst_b),
    .restart      (restart),
    .link_clk     (link_clk),
    .link_byte    (link_byte),
    .dest_kind    (dest_kind),
    .word_valid   (word_valid),
    .word_data    (word_data),
    .word_is_coef (word_is_coef),
    .cksum_valid  (cksum_valid),
    .cksum        (cksum),
    .fmt_err      (fmt_err),
    .image_done   (image_done)
  );

  boot_mem_model boot_mem_model_i (
    .link_clk  (link_clk),
    .link_byte (link_byte)
  );

  // 10 MHz system clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Collect pulses at the falling edge, where registered outputs have settled
  always @(negedge clk) begin
    if (rst_b === 1'b1) begin
      if (word_valid === 1'b1) begin
        words.push_back(word_data);
        kinds.push_back(word_is_coef);
      end
      if (cksum_valid === 1'b1) begin
        n_ck++;
        last_ck = cksum;
      end
      if (fmt_err === 1'b1) n_fmt++;
      if (image_done === 1'b1) n_done++;
    end
  end

  task automatic close_out();
    if (err_count == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic check_word(input logic [47:0] got, input logic [47:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic check_num(input int got, input int exp, input string what);
    check_count++;
    if (got != exp) begin
      err_count++;
      $display("ERROR t=%0t %s got %0d expected %0d", $time, what, got, exp);
    end
  endtask

  // New image: restart pulse, then empty the collectors
  task automatic new_image(input logic [1:0] kind);
    dest_kind = kind;
    restart   = 1'b1;
    @(negedge clk);
    restart = 1'b0;
    @(negedge clk);
    words.delete();
    kinds.delete();
    n_fmt  = 0;
    n_done = 0;
    n_ck   = 0;
  endtask

  // Header with count MS first, payload, then trailer 00 00 csMS csLS
  task automatic send_block(input logic [1:0] kind, input logic [7:0] pay[$], input logic [15:0] ck);
    logic [7:0]  img[$];
    logic [15:0] total;
    total = 16'(pay.size() + 16);
    new_image(kind);
    for (int i = 0; i < 8; i++) img.push_back(8'h40 + 8'(i));
    img.push_back(total[15:8]);
    img.push_back(total[7:0]);
    img.push_back(8'h00);
    img.push_back(8'h00);
    img = {img, pay, 8'h00, 8'h00, ck[15:8], ck[7:0]};
    boot_mem_model_i.send_image(img);
    repeat (10) @(negedge clk);
  endtask

  // Two coefficient words, top nibble set so the discard shows
  task automatic test_coef();
    logic [7:0] p[$];
    p = {8'h11, 8'h22, 8'h33, 8'hf4, 8'hff, 8'hff, 8'hff, 8'hff};
    send_block(DEST_COEF, p, 16'habcd);
    check_num(words.size(), 2, "coef word count");
    if (words.size() == 2) begin
      check_word(words[0], 48'h000004332211, "coef word 1");
      check_word(words[1], 48'h00000fffffff, "coef word 2");
      check_word(48'(kinds[1]), 48'h1, "coef kind");
    end
    check_num(n_ck, 1, "coef checksum pulses");
    check_word(48'(last_ck), 48'habcd, "coef checksum");
    check_num(n_fmt, 0, "coef format errors");
  endtask

  // Two data words, six bytes each, LS byte first
  task automatic test_data();
    logic [7:0] p[$];
    p = {8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'ha0, 8'ha1, 8'ha2, 8'ha3, 8'ha4, 8'ha5};
    send_block(DEST_DATA, p, 16'h1e2f);
    check_num(words.size(), 2, "data word count");
    if (words.size() == 2) begin
      check_word(words[0], 48'h060504030201, "data word 1");
      check_word(words[1], 48'ha5a4a3a2a1a0, "data word 2");
      check_word(48'(kinds[0]), 48'h0, "data kind");
    end
    check_num(n_ck, 1, "data checksum pulses");
    check_word(48'(last_ck), 48'h1e2f, "data checksum");
    check_num(n_fmt, 0, "data format errors");
  endtask

  // Five payload bytes: one whole word, a leftover byte, no partial word
  task automatic test_ragged();
    logic [7:0] p[$];
    p = {8'h21, 8'h43, 8'h65, 8'h07, 8'h99};
    send_block(DEST_COEF, p, 16'h0102);
    check_num(words.size(), 1, "ragged word count");
    check_num(n_fmt, 1, "ragged format error");
    check_word(48'(last_ck), 48'h0102, "ragged checksum");
  endtask

  // Zero count header opening the closing block, then a broken one
  task automatic test_term();
    logic [7:0] img[$];
    for (int i = 0; i < 20; i++) img.push_back(i == 3 ? 8'h1f : 8'h00);
    new_image(DEST_OTHER);
    boot_mem_model_i.send_image(img);
    repeat (10) @(negedge clk);
    check_num(n_done, 1, "termination seen");
    check_num(n_fmt, 0, "termination errors");
    img[19] = 8'h01;
    new_image(DEST_OTHER);
    boot_mem_model_i.send_image(img);
    repeat (10) @(negedge clk);
    check_num(n_done, 0, "bad termination done");
    check_num(n_fmt, 1, "bad termination error");
  endtask

  // Foreign block skipped by its count, then the closing block; then a memory block too short for a trailer
  task automatic test_skip_short();
    logic [7:0] img[$];
    for (int i = 0; i < 20; i++) img.push_back(i == 9 ? 8'h14 : (i == 8 ? 8'h00 : 8'h55));
    for (int i = 0; i < 20; i++) img.push_back(i == 3 ? 8'h1f : 8'h00);
    new_image(DEST_OTHER);
    boot_mem_model_i.send_image(img);
    repeat (10) @(negedge clk);
    check_num(words.size(), 0, "skipped block words");
    check_num(n_ck, 0, "skipped block checksum");
    check_num(n_done, 1, "termination after skip");
    check_num(n_fmt, 0, "skip errors");
    img.delete();
    for (int i = 0; i < 20; i++) img.push_back(i == 9 ? 8'h0e : (i < 12 ? 8'h00 : 8'hff));
    new_image(DEST_COEF);
    boot_mem_model_i.send_image(img);
    repeat (10) @(negedge clk);
    check_num(n_fmt, 1, "short block error");
    check_num(words.size(), 0, "short block words");
    check_num(n_ck, 0, "short block checksum");
    check_num(n_done, 0, "short block done");
  endtask

  initial begin
    rst_b       = 1'b0;
    restart     = 1'b0;
    dest_kind   = DEST_OTHER;
    err_count   = 0;
    check_count = 0;
    repeat (3) @(negedge clk);
    rst_b = 1'b1;
    @(negedge clk);
    test_coef();
    test_data();
    test_ragged();
    test_term();
    test_skip_short();
    close_out();
  end

  // Watchdog: whole run needs about 1500 cycles; the limit allows about thirteen times that
  initial begin
    #2000000;
    err_count++;
    close_out();
  end
endmodule
